// file: core/sap_pkg.sv
/*
 * Constants and types shared by the stereo audio port modules.
 * Assumes a 250 MHz core clock and a divided master clock on a pin.
 */
// What this block does
// RQ1: Samples wait in two four-word FIFOs, one for each channel.
// RQ2: A sequencer moves FIFO words into the output shift path.
// RQ3: An interrupt rises when the FIFOs hand over their last word.
// RQ4: The channel select clock is high for left and low for right.
// RQ5: Playback runs with no gaps between samples while FIFOs hold data.
// RQ6: The control link is a two-bit port that software toggles.
// RQ7: One sample per channel goes out in every 48 kHz period; the code takes 320 master rises per frame, 50 kHz at 16 MHz.
// RQ8: Timing comes from a master clock divided down from 64 MHz.
// RQ9: The processor reaches FIFOs, interrupt and control port by bus.
// RQ10: Serial data leaves MSB first, aligned to channel select.
// RQ11: A write clears the interrupt; an empty FIFO sends zeros.
package sap_pkg;
   // ----------------------------------------------------------------
   // sizes and counts
   // ----------------------------------------------------------------
   localparam int WORD_W = 32;
   localparam int SAMPLE_W = 16;
   localparam int FIFO_DEPTH = 4;
   localparam int BUF_DEPTH = 2;
   localparam int SAMPLE_RATE_HZ = 48000;
   localparam int SYS_CLK_HZ = 64_000_000;
   localparam int MCLK_DIV = 4;
   localparam int SLOTS_PER_FRAME = 64;
   // master clock rises per bit slot, rounded down
   localparam int MCLK_PER_BIT =
      SYS_CLK_HZ / MCLK_DIV / SAMPLE_RATE_HZ / SLOTS_PER_FRAME;
   localparam logic [2:0] BIT_LAST = 3'(MCLK_PER_BIT - 1);
   localparam logic [5:0] SLOT_LAST = 6'h3F;
   localparam logic [2:0] FIFO_FULL = 3'h4;
   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic RST_LRCK = 1'b0;
   localparam logic RST_SDA_OE = 1'b0;

   typedef enum logic {SAP_ST_IDLE, SAP_ST_RUN} sap_state_t;

   // pick one bit of a sample, zero past the sample width
   function automatic logic sap_pick(input logic [SAMPLE_W-1:0] w,
                                     input logic [4:0] idx);
      sap_pick = idx[4] ? 1'b0 : w[4'hF - idx[3:0]];
   endfunction : sap_pick
endpackage : sap_pkg

// file: core/sap_word_if.sv
/*
 * Valid/ready word carrier between the buffer and the sequencer.
 * Assumes both ends share one clock.
 */
`timescale 1ns/1ps
interface sap_word_if;
   logic valid;
   logic ready;
   logic [31:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : sap_word_if

// file: core/sap_pair_buf.sv
/*
 * Two-entry buffer on the processor write path.
 * Assumes the drain side may stall for any number of cycles.
 */
`timescale 1ns/1ps
module sap_pair_buf (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // fill side
   input wire logic in_valid,
   input wire logic [31:0] in_data,
   output logic in_ready,
   // drain side
   sap_word_if.src out
);
   logic [31:0] mem [sap_pkg::BUF_DEPTH];
   logic wp_reg, wp_next, rp_reg, rp_next;
   logic [1:0] cnt_reg, cnt_next;
   logic rdy_reg, rdy_next;
   logic push, pop;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      push = in_valid && rdy_reg;
      pop = out.ready && (cnt_reg != 2'h0);
      wp_next = wp_reg ^ push;
      rp_next = rp_reg ^ pop;
      cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
      // registered ready: stall reaches the writer one cycle late is
      // avoided since full is judged on the next count
      rdy_next = (cnt_next != 2'h2);
   end

   // registers; storage needs no reset
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wp_reg <= 1'b0;
         rp_reg <= 1'b0;
         cnt_reg <= 2'h0;
         rdy_reg <= 1'b1;
      end else if (ce) begin
         if (push) begin
            mem[wp_reg] <= in_data;
         end
         wp_reg <= wp_next;
         rp_reg <= rp_next;
         cnt_reg <= cnt_next;
         rdy_reg <= rdy_next;
      end
   end

   assign in_ready = rdy_reg;
   assign out.valid = (cnt_reg != 2'h0);
   assign out.data = mem[rp_reg];
endmodule : sap_pair_buf

// file: core/sap_audio_port.sv
/*
 * Serial audio port toward a stereo DAC, plus the software-driven
 * two-bit control port. Assumes writes arrive from bus glue on clk and
 * the divided master clock arrives on a pin from another domain.
 */
`timescale 1ns/1ps
module sap_audio_port (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // processor side: left in [31:16], right in [15:0]
   input wire logic play_en,
   input wire logic wr_valid,
   input wire logic [31:0] wr_data,
   output logic wr_ready,
   output logic irq,
   // software control bits
   input wire logic scl_sw,
   input wire logic sda_sw,
   output logic sda_in_sw,
   // dac pins
   input wire logic master_clk_in,
   output logic master_clk,
   output logic channel_select_clock,
   output logic serial_sample_out,
   output logic dac_scl,
   output logic dac_sda_out,
   output logic dac_sda_oe,
   input wire logic dac_sda_in
);
   sap_word_if wif ();

   // ----------------------------------------------------------------
   // write buffer
   // ----------------------------------------------------------------
   sap_pair_buf u_buf (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .in_valid(wr_valid),
      .in_data(wr_data),
      .in_ready(wr_ready),
      .out(wif.src)
   );

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [2:0] mc_sync_reg, mc_sync_next;
   logic [2:0] sda_sync_reg, sda_sync_next;
   logic mc_lvl_reg, mc_lvl_next;
   logic sda_lvl_reg, sda_lvl_next;
   logic mc_rise;

   // a level counts only once stages two and three agree
   always_comb begin
      mc_sync_next = {mc_sync_reg[1:0], master_clk_in};
      sda_sync_next = {sda_sync_reg[1:0], dac_sda_in};
      mc_lvl_next = (mc_sync_reg[1] == mc_sync_reg[2]) ?
                    mc_sync_reg[2] : mc_lvl_reg;
      sda_lvl_next = (sda_sync_reg[1] == sda_sync_reg[2]) ?
                     sda_sync_reg[2] : sda_lvl_reg;
      mc_rise = mc_lvl_next && !mc_lvl_reg;   // RQ8
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mc_sync_reg <= 3'h0;
         sda_sync_reg <= 3'h7;
         mc_lvl_reg <= 1'b0;
         sda_lvl_reg <= 1'b1;
      end else if (ce) begin
         mc_sync_reg <= mc_sync_next;
         sda_sync_reg <= sda_sync_next;
         mc_lvl_reg <= mc_lvl_next;
         sda_lvl_reg <= sda_lvl_next;
      end
   end

   // ----------------------------------------------------------------
   // control port: plain bits, software does the protocol
   // ----------------------------------------------------------------
   logic scl_reg, oe_reg, sdain_reg;

   // open drain: drive low only, release for a one
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         scl_reg <= 1'b1;
         oe_reg <= sap_pkg::RST_SDA_OE;
         sdain_reg <= 1'b1;
      end else if (ce) begin
         scl_reg <= scl_sw;       // RQ6
         oe_reg <= !sda_sw;       // RQ6
         sdain_reg <= sda_lvl_reg;   // RQ6
      end
   end

   // ----------------------------------------------------------------
   // channel fifos and sequencer
   // ----------------------------------------------------------------
   logic [15:0] left_mem [sap_pkg::FIFO_DEPTH];
   logic [15:0] right_mem [sap_pkg::FIFO_DEPTH];
   logic [1:0] wp_reg, wp_next, rp_reg, rp_next;
   logic [2:0] cnt_reg, cnt_next;
   sap_pkg::sap_state_t state_reg, state_next;
   logic [2:0] div_reg, div_next;
   logic [5:0] slot_reg, slot_next;
   logic [15:0] lw_reg, lw_next, rw_reg, rw_next;
   logic lrck_reg, lrck_next, sdo_reg, sdo_next;
   logic irq_reg, irq_next, mclk_reg;
   logic push, pop, tick;

   assign wif.ready = (cnt_reg != sap_pkg::FIFO_FULL);   // RQ1

   always_comb begin
      state_next = state_reg;
      div_next = div_reg;
      slot_next = slot_reg;
      lw_next = lw_reg;
      rw_next = rw_reg;
      lrck_next = lrck_reg;
      sdo_next = sdo_reg;
      pop = 1'b0;
      tick = 1'b0;
      push = wif.valid && wif.ready;   // RQ9
      case (state_reg)
         sap_pkg::SAP_ST_IDLE: begin
            slot_next = sap_pkg::SLOT_LAST;
            div_next = 3'h0;
            lrck_next = sap_pkg::RST_LRCK;
            sdo_next = 1'b0;
            if (play_en) begin
               state_next = sap_pkg::SAP_ST_RUN;
            end
         end
         sap_pkg::SAP_ST_RUN: begin
            if (!play_en) begin
               state_next = sap_pkg::SAP_ST_IDLE;
            end else if (mc_rise) begin
               tick = (div_reg == sap_pkg::BIT_LAST);   // RQ7
               div_next = tick ? 3'h0 : div_reg + 3'h1;
            end
            if (tick) begin
               slot_next = slot_reg + 6'h01;   // RQ5
               if (slot_next == 6'h00) begin
                  // empty fifo sends silence rather than stalling
                  pop = (cnt_reg != 3'h0);   // RQ2
                  lw_next = pop ? left_mem[rp_reg] : 16'h0000;   // RQ11
                  rw_next = pop ? right_mem[rp_reg] : 16'h0000;  // RQ11
               end
               lrck_next = !slot_next[5];   // RQ4
               sdo_next = slot_next[5] ?   // RQ10
                  sap_pkg::sap_pick(rw_next, slot_next[4:0]) :
                  sap_pkg::sap_pick(lw_next, slot_next[4:0]);
            end
         end
         default: begin
            state_next = sap_pkg::SAP_ST_IDLE;
         end
      endcase
      wp_next = wp_reg + {1'b0, push};
      rp_next = rp_reg + {1'b0, pop};
      cnt_next = cnt_reg + {2'h0, push} - {2'h0, pop};
      // last word handed over raises it; a refill write clears it,
      // but a new raise in the same cycle wins
      if (pop && cnt_next == 3'h0) begin
         irq_next = 1'b1;   // RQ3
      end else if (push) begin
         irq_next = 1'b0;   // RQ11
      end else begin
         irq_next = irq_reg;
      end
   end

   // sequencer and fifo registers; storage needs no reset
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_reg <= sap_pkg::SAP_ST_IDLE;
         div_reg <= 3'h0;
         slot_reg <= sap_pkg::SLOT_LAST;
         lw_reg <= 16'h0000;
         rw_reg <= 16'h0000;
         lrck_reg <= sap_pkg::RST_LRCK;
         sdo_reg <= 1'b0;
         irq_reg <= 1'b0;
         mclk_reg <= 1'b0;
         wp_reg <= 2'h0;
         rp_reg <= 2'h0;
         cnt_reg <= 3'h0;
      end else if (ce) begin
         if (push) begin
            left_mem[wp_reg] <= wif.data[31:16];   // RQ1
            right_mem[wp_reg] <= wif.data[15:0];   // RQ1
         end
         state_reg <= state_next;
         div_reg <= div_next;
         slot_reg <= slot_next;
         lw_reg <= lw_next;
         rw_reg <= rw_next;
         lrck_reg <= lrck_next;
         sdo_reg <= sdo_next;
         irq_reg <= irq_next;
         mclk_reg <= mc_lvl_reg;   // RQ8
         wp_reg <= wp_next;
         rp_reg <= rp_next;
         cnt_reg <= cnt_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs, all from flops except the tied-low dac_sda_out
   // ----------------------------------------------------------------
   assign irq = irq_reg;
   assign master_clk = mclk_reg;
   assign channel_select_clock = lrck_reg;
   assign serial_sample_out = sdo_reg;
   assign dac_scl = scl_reg;
   assign dac_sda_out = 1'b0;
   assign dac_sda_oe = oe_reg;
   assign sda_in_sw = sdain_reg;
endmodule : sap_audio_port

// file: tb/sap_audio_port_props.sv
/* pin-level checker for sap_audio_port, bound to every instance.
   assumes ce high in the bench and one clk domain. */
`timescale 1ns/1ps
module sap_audio_port_chk (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // processor side
   input wire logic play_en,
   input wire logic wr_valid,
   input wire logic wr_ready,
   input wire logic irq,
   // control link and dac pins
   input wire logic scl_sw,
   input wire logic sda_sw,
   input wire logic master_clk_in,
   input wire logic master_clk,
   input wire logic channel_select_clock,
   input wire logic serial_sample_out,
   input wire logic dac_scl,
   input wire logic dac_sda_out,
   input wire logic dac_sda_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ----------------------------------------------------------
   // half-frame timer: cycles since the select clock last moved
   // ----------------------------------------------------------
   // bench master clock period is 16 clk cycles
   localparam int HALF = 32 * 16 * sap_pkg::MCLK_PER_BIT;
   localparam int TAIL = 16 * 16 * sap_pkg::MCLK_PER_BIT;
   logic [11:0] hcnt_reg;
   logic seen_reg;
   // seen from the first select move inside one playback run
   always_ff @(posedge clk) begin
      hcnt_reg <= $changed(channel_select_clock) ? 12'h000 :
         hcnt_reg + 12'h001;
      seen_reg <= play_en & (seen_reg | $changed(channel_select_clock));
   end
   sequence s_take;
      ce && irq && wr_valid && wr_ready;
   endsequence
   sequence s_sel_move;
      $changed(channel_select_clock) && seen_reg && play_en;
   endsequence
   chk_scl_follow: assert property (
      ce && $past(rst_n) |-> dac_scl == $past(scl_sw))
      else $error("control clock pin does not follow software bit");
   chk_sda_drive: assert property (
      ce && $past(rst_n) |-> dac_sda_oe == !$past(sda_sw))
      else $error("data pin enable does not follow software bit");
   chk_sda_low: assert property (dac_sda_out == 1'b0)
      else $error("open-drain data pin drives high");
   chk_reset_pins: assert property (disable iff (1'b0) !rst_n |=>
      wr_ready && !irq && !channel_select_clock && !serial_sample_out)
      else $error("pins wrong after reset");
   // a half is exactly HALF cycles; the timer reads HALF - 1 at the move
   chk_half_span: assert property (s_sel_move |->
      hcnt_reg >= HALF - 3 && hcnt_reg <= HALF + 2)
      else $error("channel half length wrong");
   chk_tail_zero: assert property (seen_reg && play_en &&
      hcnt_reg >= TAIL + 8 && hcnt_reg <= HALF - 8 |-> !serial_sample_out)
      else $error("unused slot carries data");
   chk_irq_left: assert property ($rose(irq) |-> channel_select_clock)
      else $error("interrupt raised outside the left pop");
   // two cycles: later a frame-start pop may legally raise it again
   chk_irq_clear: assert property (s_take |-> ##2 !irq)
      else $error("write did not clear interrupt");
   chk_master_sync: assert property (
      $rose(master_clk) |-> $past(master_clk_in, 2))
      else $error("master clock copy rose without input");
endmodule : sap_audio_port_chk
bind sap_audio_port sap_audio_port_chk i_sap_audio_port_chk (.clk, .rst_n,
   .ce, .play_en, .wr_valid, .wr_ready, .irq, .scl_sw, .sda_sw,
   .master_clk_in, .master_clk, .channel_select_clock, .serial_sample_out,
   .dac_scl, .dac_sda_out, .dac_sda_oe);

// file: tb/sap_dac_model.sv
/* behavioural stereo dac: master clock source, mid-slot serial capture,
   pulled-up control data line. assumes a master period of 16 clk
   cycles and MCLK_PER_BIT master periods per bit slot. */
`timescale 1ns/1ps
module sap_dac_model (
   // clock
   input wire logic clk,
   // audio pins
   output logic master_clk_in,
   input wire logic channel_select_clock,
   input wire logic serial_sample_out,
   // control data line
   input wire logic dac_sda_out,
   input wire logic dac_sda_oe,
   input wire logic pull_lo,
   output logic dac_sda_in,
   // captured words
   output logic [15:0] left_word,
   output logic [15:0] right_word,
   output logic fr_done
);
   // clk cycles per bit slot: 64 ns master period over a 4 ns clk
   localparam int SLOT_CYC = 16 * sap_pkg::MCLK_PER_BIT;
   logic sel_q;
   logic [15:0] sh;
   int ph = 0;
   int nb = 16;
   // free-running master clock, phase unrelated to clk
   initial begin
      master_clk_in = 1'b0;
      #13;
      forever #32 master_clk_in = ~master_clk_in;
   end
   // pull-up: any party pulling low wins
   assign dac_sda_in = (dac_sda_oe & ~dac_sda_out) | pull_lo ? 1'b0 : 1'b1;
   // bit counter parks at 16 so nothing is captured while idle
   always @(posedge clk) begin
      sel_q <= channel_select_clock;
      fr_done <= 1'b0;
      if (sel_q != channel_select_clock) begin
         ph <= 0;
         nb <= 0;
      end else if (nb < 16) begin
         ph <= (ph == SLOT_CYC - 1) ? 0 : ph + 1;
         if (ph == SLOT_CYC - 1) nb <= nb + 1;
         // sample in mid-slot, well clear of both data edges
         if (ph == SLOT_CYC / 2) begin
            sh <= {sh[14:0], serial_sample_out};
            if (nb == 15 && sel_q) begin
               left_word <= {sh[14:0], serial_sample_out};
            end
            if (nb == 15 && !sel_q) begin
               right_word <= {sh[14:0], serial_sample_out};
               fr_done <= 1'b1;
            end
         end
      end
   end
endmodule : sap_dac_model

// file: tb/sap_audio_port_tb.sv
/* self-checking bench for sap_audio_port beside a behavioural dac.
   inputs change on rising clk, outputs are read on falling clk. */
`timescale 1ns/1ps
module sap_audio_port_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic play_en = 1'b0;
   logic wr_valid = 1'b0;
   logic [31:0] wr_data = 32'h0;
   logic scl_sw = 1'b1;
   logic sda_sw = 1'b1;
   logic pull_lo = 1'b0;
   logic wr_ready, irq, sda_in_sw, master_clk_in, master_clk, dac_scl;
   logic channel_select_clock, serial_sample_out, fr_done;
   logic dac_sda_out, dac_sda_oe, dac_sda_in;
   logic [15:0] left_word, right_word;
   int err_count = 0;
   int tests_run = 0;
   int cycles = 0;
   sap_audio_port i_sap_audio_port (.clk(clk), .rst_n(rst_n), .ce(1'b1),
      .play_en(play_en), .wr_valid(wr_valid), .wr_data(wr_data),
      .wr_ready(wr_ready), .irq(irq), .scl_sw(scl_sw), .sda_sw(sda_sw),
      .sda_in_sw(sda_in_sw), .master_clk_in(master_clk_in),
      .master_clk(master_clk), .channel_select_clock(channel_select_clock),
      .serial_sample_out(serial_sample_out), .dac_scl(dac_scl),
      .dac_sda_out(dac_sda_out), .dac_sda_oe(dac_sda_oe),
      .dac_sda_in(dac_sda_in));
   sap_dac_model i_sap_dac_model (.clk(clk), .master_clk_in(master_clk_in),
      .channel_select_clock(channel_select_clock),
      .serial_sample_out(serial_sample_out), .dac_sda_out(dac_sda_out),
      .dac_sda_oe(dac_sda_oe), .pull_lo(pull_lo), .dac_sda_in(dac_sda_in),
      .left_word(left_word), .right_word(right_word), .fr_done(fr_done));
   always #2 clk = ~clk;
   // watchdog: eight frames of 5120 cycles need about 41000 cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         err_count++;
         close_out();
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : close_out
   // distinct sample pair per index
   function automatic logic [31:0] pat(input int k);
      pat = {16'h8001 + 16'(k), 16'h4C70 - 16'(k)};
   endfunction : pat
   // request held until a falling edge shows ready, dropped after the take
   task automatic wr(input logic [31:0] d);
      @(posedge clk) begin
         wr_valid <= 1'b1;
         wr_data <= d;
      end
      do @(negedge clk); while (!wr_ready);
      @(posedge clk) wr_valid <= 1'b0;
   endtask : wr
   task automatic wait_fr();
      do @(negedge clk); while (!fr_done);
   endtask : wait_fr
   task automatic t_ctrl();
      for (int b = 0; b < 8; b++) begin
         @(posedge clk) begin
            scl_sw <= b[0];
            sda_sw <= b[1];
            pull_lo <= b[2];
         end
         repeat (8) @(negedge clk);
         chk("scl pin", dac_scl, b[0]);
         chk("sda enable", dac_sda_oe, !b[1]);
         chk("sda read", sda_in_sw, b[1] & !b[2]);
      end
      @(posedge clk) pull_lo <= 1'b0;
      $display("control test done");
   endtask : t_ctrl
   // six pairs fill fifo and buffer; a seventh offer must be ignored
   task automatic t_fill();
      for (int k = 0; k < 6; k++) wr(pat(k));
      repeat (4) @(negedge clk);
      chk("full ready", wr_ready, 1'b0);
      @(posedge clk) begin
         wr_valid <= 1'b1;
         wr_data <= 32'hF0F0F0F0;
      end
      repeat (8) @(negedge clk);
      chk("refused ready", wr_ready, 1'b0);
      @(posedge clk) wr_valid <= 1'b0;
      $display("fill test done");
   endtask : t_fill
   task automatic t_play();
      @(posedge clk) play_en <= 1'b1;
      for (int k = 0; k < 7; k++) begin
         if (k == 6) wr(pat(6));
         if (k == 6) repeat (4) @(negedge clk);
         if (k == 6) chk("irq clear", irq, 1'b0);
         wait_fr();
         chk("left", left_word, pat(k) >> 16);
         chk("right", right_word, pat(k) & 32'h0000FFFF);
         chk("irq", irq, k >= 5);
      end
      wait_fr();
      chk("empty frame", {left_word, right_word}, 32'h0);
      @(posedge clk) play_en <= 1'b0;
      $display("play test done");
   endtask : t_play
   initial begin
      repeat (12) @(posedge clk);
      @(negedge clk);
      chk("reset pins", {wr_ready, irq, dac_scl, dac_sda_oe, sda_in_sw,
         channel_select_clock, serial_sample_out, master_clk}, 8'hA8);
      $display("reset test done");
      @(posedge clk) rst_n <= 1'b1;
      t_ctrl();
      t_fill();
      t_play();
      close_out();
   end
endmodule : sap_audio_port_tb
